/* File: alert_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Watermark inputs and alert results between the top and the comparator
interface alert_if;
  logic [6:0] byte_count;
  logic [5:0] threshold;
  logic high_alert;
  logic low_alert;
  modport top (output byte_count, output threshold, input high_alert, input low_alert);
  modport cmp (input byte_count, input threshold, output high_alert, output low_alert);
endinterface : alert_if
`default_nettype wire

/* File: crc_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crc_engine_model #(
  parameter int RUN_CYCLES = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Launch request
  input wire logic start,
  input wire logic want_zero,
  input wire logic want_standalone,
  // Status toward the block
  output logic crc_busy,
  output logic crc_finish,
  output logic crc_zero,
  output logic crc_standalone
);
  int count_q;
  ////////////////////////////////////////////////////////////////
  // Busy for a fixed run, then a one-cycle finish pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= 0;
      crc_busy <= 1'b0;
      crc_finish <= 1'b0;
    end else begin
      crc_finish <= 1'b0;
      if (start && !crc_busy) begin
        crc_busy <= 1'b1;
        count_q <= RUN_CYCLES;
      end else if (crc_busy) begin
        count_q <= count_q - 1;
        if (count_q == 1) begin
          crc_busy <= 1'b0;
          crc_finish <= 1'b1;
        end
      end
    end
  end
  // result only with finish
  // Outside the pulse the result flips, so the block cannot lean on it
  assign crc_zero = crc_finish ? want_zero : ~want_zero;
  // Launch kind only with finish; other runs leave the done flag cleared by busy
  assign crc_standalone = crc_finish && want_standalone;
endmodule : crc_engine_model
`default_nettype wire

/* File: reader_status_registers.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module reader_status_registers
  import status_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CRC coprocessor status
  input wire logic crc_busy,
  input wire logic crc_finish,
  input wire logic crc_zero,
  input wire logic crc_standalone,
  // Interrupt sources from other units, with their enables
  input wire logic [7:0] comm_requests,
  input wire logic [7:0] comm_interrupt_enables,
  input wire logic [7:0] misc_requests,
  input wire logic [7:0] misc_interrupt_enables,
  // Timer
  input wire logic timer_enabled,
  input wire logic timer_gated_mode,
  input wire logic timer_counting,
  // FIFO
  input wire logic [6:0] buffer_byte_count,
  input wire logic [5:0] watermark_threshold,
  // Transceiver and security
  input wire logic [2:0] transceiver_state,
  input wire logic auth_success,
  input wire logic temp_above_limit,
  // Outputs to other units
  output logic overtemperature_clear,
  output logic serial_filter_highspeed_force,
  output logic encryption_active,
  output logic high_watermark_request,
  output logic low_watermark_request,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Watermark compare

  alert_if aif ();
  assign aif.byte_count = buffer_byte_count;
  assign aif.threshold = watermark_threshold;
  watermark_compare u_cmp (.a(aif.cmp));

  logic high_alert;
  logic low_alert;
  // alerts follow live count each cycle
  assign high_alert = aif.high_alert;
  assign low_alert = aif.low_alert;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_primary;
  logic wr_trans;
  logic wr_req;
  logic wr_mask;
  assign wr_primary = reg_wr && (reg_addr == PRIMARY_STATUS_ADDR);
  assign wr_trans = reg_wr && (reg_addr == TRANSCEIVER_STATUS_ADDR);
  assign wr_req = reg_wr && (reg_addr == REQUEST_STATUS_ADDR);
  assign wr_mask = reg_wr && (reg_addr == REQUEST_MASK_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // CRC flags

  logic crc_good_q;
  logic crc_good_d;
  logic crc_done_q;
  logic crc_done_d;
  // low while busy, zero result on finish
  assign crc_good_d = crc_busy ? 1'b0 : (crc_finish ? crc_zero : crc_good_q);
  // done only for the standalone command; a new run clears it
  assign crc_done_d = (crc_finish && crc_standalone) ? 1'b1 : (crc_busy ? 1'b0 : crc_done_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc_good_q <= PRIMARY_STATUS_RESET[CRC_GOOD_BIT];
      crc_done_q <= PRIMARY_STATUS_RESET[CRC_DONE_BIT];
    end else begin
      crc_good_q <= crc_good_d;
      crc_done_q <= crc_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined interrupt and timer

  logic combined_irq;
  logic timer_active_flag;
  // any enabled source in either group
  assign combined_irq = |(comm_requests & comm_interrupt_enables) |
                        |(misc_requests & misc_interrupt_enables);
  // running means counting on next tick
  // gated mode looks only at the enable
  assign timer_active_flag = timer_gated_mode ? timer_enabled : (timer_enabled && timer_counting);

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver status

  logic temp_clear_q;
  logic hs_force_q;
  logic crypto_q;
  logic temp_clear_ok;
  // clear only below the alarm limit
  assign temp_clear_ok = wr_trans && reg_wdata[TEMP_CLEAR_BIT] && !temp_above_limit;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      temp_clear_q <= TRANSCEIVER_STATUS_RESET[TEMP_CLEAR_BIT];
      hs_force_q <= TRANSCEIVER_STATUS_RESET[HS_FORCE_BIT];
    end else if (wr_trans) begin
      temp_clear_q <= reg_wdata[TEMP_CLEAR_BIT];
      hs_force_q <= reg_wdata[HS_FORCE_BIT];
    end
  end

  // set by a good authentication, software clears; set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crypto_q <= TRANSCEIVER_STATUS_RESET[CRYPTO_BIT];
    end else if (auth_success) begin
      crypto_q <= 1'b1;
    end else if (wr_trans && !reg_wdata[CRYPTO_BIT]) begin
      crypto_q <= 1'b0;
    end
  end

  logic clear_pulse_q;
  // One-cycle clear toward the temperature sensor
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clear_pulse_q <= 1'b0;
    end else begin
      clear_pulse_q <= temp_clear_ok;
    end
  end
  assign overtemperature_clear = clear_pulse_q;
  assign serial_filter_highspeed_force = hs_force_q;
  assign encryption_active = crypto_q;

  ////////////////////////////////////////////////////////////////////////////
  // Watermark requests, mask and interrupt line

  logic [1:0] req_q;
  logic [1:0] req_d;
  logic [1:0] mask_q;
  logic [1:0] alert_vec;
  logic [1:0] alert_prev_q;
  logic [1:0] alert_rise;
  assign alert_vec = {high_alert, low_alert};
  assign alert_rise = alert_vec & ~alert_prev_q;
  // latch each assertion; write one clears; set beats clear
  assign req_d = alert_rise | (req_q & ~(wr_req ? reg_wdata[1:0] : 2'h0));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_q <= 2'h0;
      alert_prev_q <= 2'h0;
      mask_q <= 2'h0;
    end else begin
      req_q <= req_d;
      alert_prev_q <= alert_vec;
      if (wr_mask) begin
        mask_q <= reg_wdata[1:0];
      end
    end
  end
  assign high_watermark_request = req_q[REQ_HIGH];
  assign low_watermark_request = req_q[REQ_LOW];
  // Level output while any unmasked request stands
  assign irq = |(req_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] primary_value;
  logic [7:0] trans_value;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  // reserved bits 7 and 2 read zero; writes here are ignored
  assign primary_value = {1'b0, crc_good_q, crc_done_q, combined_irq, timer_active_flag,
                          1'b0, high_alert, low_alert};
  // state field passes the transceiver encoding
  assign trans_value = {temp_clear_q, hs_force_q, 2'h0, crypto_q, transceiver_state};
  assign rdata_d = (reg_addr == PRIMARY_STATUS_ADDR) ? primary_value :
                   (reg_addr == TRANSCEIVER_STATUS_ADDR) ? trans_value :
                   (reg_addr == REQUEST_STATUS_ADDR) ? {6'h0, req_q} :
                   (reg_addr == REQUEST_MASK_ADDR) ? {6'h0, mask_q} : 8'h00;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Named steps shared by the checks below
  sequence primary_read;
    reg_rd && reg_addr == PRIMARY_STATUS_ADDR;
  endsequence
  sequence trans_read;
    reg_rd && reg_addr == TRANSCEIVER_STATUS_ADDR;
  endsequence
  sequence crc_run_end;
    !crc_busy && crc_finish;
  endsequence
  sequence low_rise;
    low_alert && !$past(low_alert);
  endsequence
  sequence high_rise;
    high_alert && !$past(high_alert);
  endsequence

  a_primary_reserved: assert property (@(posedge core_clk) disable iff (rst)
    primary_read |=> (reg_rdata[7] == 1'b0) && (reg_rdata[2] == 1'b0))
    else $error("primary reserved bit set");
  a_primary_ro: assert property (@(posedge core_clk) disable iff (rst)
    (wr_primary && !crc_busy && !crc_finish) |=> $stable(crc_good_q) && $stable(crc_done_q))
    else $error("primary write changed a flag");
  a_crc_good_low: assert property (@(posedge core_clk) disable iff (rst)
    crc_busy |=> !crc_good_q) else $error("crc good not low while busy");
  a_crc_good_rise: assert property (@(posedge core_clk) disable iff (rst)
    crc_run_end ##0 crc_zero |=> crc_good_q) else $error("crc good not set");
  a_crc_good_fail: assert property (@(posedge core_clk) disable iff (rst)
    crc_run_end ##0 !crc_zero |=> !crc_good_q) else $error("crc good set on bad result");
  a_crc_good_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!crc_busy && !crc_finish) |=> $stable(crc_good_q)) else $error("crc good moved");
  a_crc_done_set: assert property (@(posedge core_clk) disable iff (rst)
    (crc_finish && crc_standalone) |=> crc_done_q) else $error("crc done not set");
  a_crc_done_clear: assert property (@(posedge core_clk) disable iff (rst)
    (crc_busy && !crc_finish) |=> !crc_done_q) else $error("crc done not cleared");
  // enabled comm source shows on read
  a_irq_flag_read: assert property (@(posedge core_clk) disable iff (rst)
    primary_read ##0 (|(comm_requests & comm_interrupt_enables))
    |=> reg_rdata[IRQ_BIT]) else $error("combined interrupt missing");
  // enabled misc source shows on read
  a_irq_flag_misc: assert property (@(posedge core_clk) disable iff (rst)
    primary_read ##0 (|(misc_requests & misc_interrupt_enables))
    |=> reg_rdata[IRQ_BIT]) else $error("combined misc interrupt missing");
  a_irq_flag_quiet: assert property (@(posedge core_clk) disable iff (rst)
    primary_read ##0 (!(|(comm_requests & comm_interrupt_enables)) &&
    !(|(misc_requests & misc_interrupt_enables)))
    |=> !reg_rdata[IRQ_BIT]) else $error("combined interrupt without source");
  a_timer_count: assert property (@(posedge core_clk) disable iff (rst)
    primary_read ##0 (timer_enabled && timer_counting)
    |=> reg_rdata[TIMER_BIT]) else $error("running timer not shown");
  a_timer_free: assert property (@(posedge core_clk) disable iff (rst)
    primary_read ##0 (!timer_gated_mode && !(timer_enabled && timer_counting))
    |=> !reg_rdata[TIMER_BIT]) else $error("idle timer shown active");
  a_timer_gated: assert property (@(posedge core_clk) disable iff (rst)
    primary_read ##0 (timer_gated_mode && timer_enabled)
    |=> reg_rdata[TIMER_BIT]) else $error("gated timer flag");
  a_high_alert_eq: assert property (@(posedge core_clk) disable iff (rst)
    ((7'(FIFO_DEPTH) - buffer_byte_count) <= {1'b0, watermark_threshold}) == high_alert)
    else $error("high alert mismatch");
  a_low_alert_eq: assert property (@(posedge core_clk) disable iff (rst)
    (buffer_byte_count <= {1'b0, watermark_threshold}) == low_alert) else $error("low alert");
  a_trans_reserved: assert property (@(posedge core_clk) disable iff (rst)
    trans_read |=> reg_rdata[5:4] == 2'h0) else $error("transceiver reserved bit set");
  a_state_field: assert property (@(posedge core_clk) disable iff (rst)
    trans_read |=> reg_rdata[2:0] == $past(transceiver_state)) else $error("state field");
  a_temp_clear_gate: assert property (@(posedge core_clk) disable iff (rst)
    (wr_trans && temp_above_limit) |=> !overtemperature_clear) else $error("hot clear");
  a_temp_clear_pulse: assert property (@(posedge core_clk) disable iff (rst)
    (wr_trans && reg_wdata[TEMP_CLEAR_BIT] && !temp_above_limit) |=> overtemperature_clear)
    else $error("temperature clear missing");
  a_crypto_set: assert property (@(posedge core_clk) disable iff (rst)
    auth_success |=> encryption_active) else $error("crypto not set");
  a_crypto_clear: assert property (@(posedge core_clk) disable iff (rst)
    (wr_trans && !reg_wdata[CRYPTO_BIT] && !auth_success) |=> !encryption_active)
    else $error("crypto not cleared");
  a_request_latch: assert property (@(posedge core_clk) disable iff (rst)
    low_rise |=> low_watermark_request) else $error("low req lost");
  a_high_latch: assert property (@(posedge core_clk) disable iff (rst)
    high_rise |=> high_watermark_request) else $error("high req lost");
  // Read data drops back to zero without a strobe
  a_read_idle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data lingers");

endmodule : reader_status_registers
`default_nettype wire

/* File: reader_status_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reader_status_registers_bench;
  import status_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic [7:0] comm_req = '0, comm_en = '0, misc_req = '0, misc_en = '0;
  logic crc_busy, crc_finish, crc_zero, crc_standalone, crc_start = 1'b0, crc_want = 1'b0;
  logic crc_alone = 1'b0;
  logic tmr_en = 1'b0, tmr_gated = 1'b0, tmr_cnt = 1'b0, auth = 1'b0, hot = 1'b0;
  logic [6:0] count = '0;
  logic [5:0] thr = '0;
  logic [2:0] xstate = '0;
  logic oc, hs, enc, hreq, lreq, irq, oc_seen;
  int failures = 0, checked = 0, cycles = 0;
  int wc[6] = '{60, 59, 4, 5, 64, 0};
  int wt[6] = '{4, 4, 4, 4, 0, 63};
  ////////////////////////////////////////////////////////////////
  reader_status_registers dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crc_busy(crc_busy), .crc_finish(crc_finish), .crc_zero(crc_zero),
    .crc_standalone(crc_standalone), .comm_requests(comm_req), .comm_interrupt_enables(comm_en),
    .misc_requests(misc_req), .misc_interrupt_enables(misc_en), .timer_enabled(tmr_en),
    .timer_gated_mode(tmr_gated), .timer_counting(tmr_cnt), .buffer_byte_count(count),
    .watermark_threshold(thr), .transceiver_state(xstate), .auth_success(auth),
    .temp_above_limit(hot), .overtemperature_clear(oc), .serial_filter_highspeed_force(hs),
    .encryption_active(enc), .high_watermark_request(hreq), .low_watermark_request(lreq),
    .irq(irq));
  crc_engine_model crc (.core_clk(core_clk), .rst(rst), .start(crc_start),
    .want_zero(crc_want), .crc_busy(crc_busy), .crc_finish(crc_finish), .crc_zero(crc_zero),
    .crc_standalone(crc_standalone), .want_standalone(crc_alone));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Write strobe one cycle; clear pulse captured in the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1 oc_seen = oc;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input string name, input logic [7:0] a, m, exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata & m, exp);
  endtask : rdchk
  task automatic crc_run(input logic z, input logic sa);
    int n;
    n = 0;
    @(posedge core_clk);
    crc_start <= 1'b1;
    crc_want <= z;
    crc_alone <= sa;
    @(posedge core_clk);
    crc_start <= 1'b0;
    rdchk("crc_running", 8'h07, 8'h60, 8'h00);
    while (crc_finish !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    rdchk("crc_result", 8'h07, 8'h60, {1'b0, z, sa, 5'h00});
  endtask : crc_run
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rdchk("primary_reset", 8'h07, 8'hff, 8'h21);
    @(posedge core_clk);
    #1 chk("rdata_drop", reg_rdata, 8'h00);
    rdchk("xcvr_reset", 8'h08, 8'hff, 8'h00);
    rdchk("unmapped", 8'h20, 8'hff, 8'h00);
    wr(8'h07, 8'hde);
    rdchk("primary_ro", 8'h07, 8'hff, 8'h21);
    // Watermark edges on both sides of the threshold
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      count <= wc[i][6:0];
      thr <= wt[i][5:0];
      rdchk("alerts", 8'h07, 8'h03, {6'h0, (64 - wc[i]) <= wt[i], wc[i] <= wt[i]});
    end
    // Sticky requests, mask and level output
    count <= 7'd30;
    thr <= 6'd4;
    wr(8'h10, 8'h03);
    rdchk("req_clear", 8'h10, 8'h03, 8'h00);
    count <= 7'd60;
    rdchk("req_high", 8'h10, 8'h03, 8'h02);
    count <= 7'd2;
    rdchk("req_both", 8'h10, 8'h03, 8'h03);
    chk("req_pins", {6'h0, hreq, lreq}, 8'h03);
    wr(8'h11, 8'h00);
    chk("irq_masked", {7'h0, irq}, 8'h00);
    wr(8'h11, 8'h01);
    chk("irq_on", {7'h0, irq}, 8'h01);
    rdchk("mask_back", 8'h11, 8'hff, 8'h01);
    wr(8'h10, 8'h01);
    chk("irq_off", {7'h0, irq}, 8'h00);
    rdchk("req_left", 8'h10, 8'h03, 8'h02);
    // Combined flag for every source, each bank alone
    for (int i = 0; i < 8; i++) begin
      comm_req <= 8'h01 << i;
      comm_en <= ~(8'h01 << i);
      misc_req <= 8'h80 >> i;
      misc_en <= ~(8'h80 >> i);
      rdchk("irq_flag_off", 8'h07, 8'h10, 8'h00);
      comm_en <= 8'h01 << i;
      rdchk("irq_flag_comm", 8'h07, 8'h10, 8'h10);
      comm_en <= 8'h00;
      misc_en <= 8'h80 >> i;
      rdchk("irq_flag_misc", 8'h07, 8'h10, 8'h10);
    end
    // Timer flag for all mode, enable and count combinations
    for (int k = 0; k < 8; k++) begin
      {tmr_gated, tmr_en, tmr_cnt} <= k[2:0];
      rdchk("timer", 8'h07, 8'h08, (k[2] ? k[1] : k[1] & k[0]) ? 8'h08 : 8'h00);
    end
    crc_run(1'b1, 1'b1);
    crc_run(1'b0, 1'b1);
    crc_run(1'b1, 1'b0);
    // Every transceiver state code
    for (int s = 0; s < 7; s++) begin
      xstate <= s[2:0];
      rdchk("modem", 8'h08, 8'h07, s[7:0]);
    end
    wr(8'h08, 8'hff);
    chk("temp_clear", {7'h0, oc_seen}, 8'h01);
    rdchk("xcvr_write", 8'h08, 8'hff, 8'hc6);
    chk("hs_pin", {7'h0, hs}, 8'h01);
    hot <= 1'b1;
    wr(8'h08, 8'h80);
    chk("temp_hot", {7'h0, oc_seen}, 8'h00);
    rdchk("xcvr_hot", 8'h08, 8'hff, 8'h86);
    // Encryption on by authentication, off by software
    auth <= 1'b1;
    @(posedge core_clk);
    auth <= 1'b0;
    rdchk("crypto_on", 8'h08, 8'h08, 8'h08);
    chk("crypto_pin", {7'h0, enc}, 8'h01);
    wr(8'h08, 8'h00);
    rdchk("crypto_off", 8'h08, 8'h08, 8'h00);
    finish_test();
  end
endmodule : reader_status_registers_bench
`default_nettype wire

/* File: status_pkg.sv */
// What this block does
// - The primary status register sits at 07h, resets to 21h, is read-only, bits 7 and 2 read zero.
// - The CRC good flag is low while a calculation runs and rises when it ends with a zero result.
// - The CRC good flag means nothing during transmit or receive; the host uses the checksum error bit.
// - The CRC done flag is set when a calculation finishes, valid only for the calculate command.
// - The combined interrupt flag is high while any request source is active and enabled.
// - The timer active flag is high while the timer unit is running.
// - In gated mode the timer active flag follows the enable bits and ignores the gate signal.
// - The high watermark alert is high while 64 minus the byte count is at most the threshold.
// - The low watermark alert is high while the byte count is at most the threshold.
// - The transceiver status register sits at 08h, resets to 00h, bits 7 and 6 writable, 5:4 zero.
// - The transceiver state field encodes idle, start wait, tx wait, tx, rx wait, data wait, rx.
// - Writing one to bit 7 clears the overtemperature error only below the 125 degree limit.
// - The encryption active bit is set only by a good authentication and cleared by software.
// - Each watermark alert assertion is latched into a request bit that software clears.
package status_pkg;
  localparam logic [7:0] PRIMARY_STATUS_ADDR = 8'h07;
  localparam logic [7:0] TRANSCEIVER_STATUS_ADDR = 8'h08;
  localparam logic [7:0] REQUEST_STATUS_ADDR = 8'h10;
  localparam logic [7:0] REQUEST_MASK_ADDR = 8'h11;
  localparam logic [7:0] PRIMARY_STATUS_RESET = 8'h21;
  localparam logic [7:0] TRANSCEIVER_STATUS_RESET = 8'h00;
  localparam int CRC_GOOD_BIT = 6;
  localparam int CRC_DONE_BIT = 5;
  localparam int IRQ_BIT = 4;
  localparam int TIMER_BIT = 3;
  localparam int HIGH_BIT = 1;
  localparam int LOW_BIT = 0;
  localparam int TEMP_CLEAR_BIT = 7;
  localparam int HS_FORCE_BIT = 6;
  localparam int CRYPTO_BIT = 3;
  localparam int FIFO_DEPTH = 64;
  localparam int TEMP_LIMIT_C = 125;
  // Local request bits: high alert, low alert
  localparam int REQ_HIGH = 1;
  localparam int REQ_LOW = 0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_START_WAIT = 3'h1, ST_TX_WAIT = 3'h2, ST_TX = 3'h3,
    ST_RX_WAIT = 3'h4, ST_DATA_WAIT = 3'h5, ST_RX = 3'h6
  } modem_state_t;
endpackage : status_pkg

/* File: watermark_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module watermark_compare
  import status_pkg::*;
(
  // Count and threshold in, alerts out
  alert_if.cmp a
);
  logic [7:0] free_space;
  // Free space from the stored count; widened so a count of 64 gives zero
  assign free_space = 8'(FIFO_DEPTH) - {1'b0, a.byte_count};
  assign a.high_alert = free_space <= {2'h0, a.threshold};
  assign a.low_alert = {1'b0, a.byte_count} <= {2'h0, a.threshold};
endmodule : watermark_compare
`default_nettype wire
